// *** inc/fault_classify_pkg.sv ***
// shared codes and encodings for the translation fault classifier
package fault_classify_pkg;

    localparam int REASON_W = 8;

    // fault reason codes
    localparam logic [7:0] REASON_NONE = 8'h00;
    localparam logic [7:0] REASON_BAD_PROGRAM = 8'h03;
    localparam logic [7:0] REASON_SL_NEXT_FETCH = 8'h07;
    localparam logic [7:0] REASON_ROOT_FETCH = 8'h08;
    localparam logic [7:0] REASON_CTX_FETCH = 8'h09;
    localparam logic [7:0] REASON_ROOT_RSVD = 8'h0a;
    localparam logic [7:0] REASON_CTX_RSVD = 8'h0b;
    localparam logic [7:0] REASON_SL_RSVD = 8'h0c;
    localparam logic [7:0] REASON_PID_RSVD = 8'h13;
    localparam logic [7:0] REASON_FL_TOP_FETCH = 8'h15;
    localparam logic [7:0] REASON_FL_RSVD = 8'h16;
    localparam logic [7:0] REASON_FL_NEXT_FETCH = 8'h17;

    // reset values of the answer outputs
    localparam logic [7:0] REASON_RST = 8'h00;
    localparam logic QUALIFIED_RST = 1'b0;

    // walk step reported by the table walker, in walk order
    typedef enum logic [2:0] {
        STEP_ROOT = 3'h0,
        STEP_CTX = 3'h1,
        STEP_PID = 3'h2,
        STEP_SL_TOP = 3'h3,
        STEP_SL_NEXT = 3'h4,
        STEP_FL_TOP = 3'h5,
        STEP_FL_NEXT = 3'h6
    } step_kind_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'h0,
        ST_WALK = 2'h1,
        ST_ANSWER = 2'h2
    } walk_state_t;

endpackage

// *** core/fault_classify.sv ***
// classifier of non-recoverable faults for translation requests with a process id
`timescale 1ns/1ps

module fault_classify
    import fault_classify_pkg::*;
#(
    parameter int LEVELS = 5
) (
    input wire logic clk, // core clock
    input wire logic reset_n, // asynchronous reset
    input wire logic req_start, // pulse: a request with process id begins
    input wire logic step_valid, // pulse: one walk step result
    input wire logic [2:0] step_kind, // which structure was fetched
    input wire logic step_last, // step is the final one of the walk
    input wire logic fetch_err, // fetch of this entry failed
    input wire logic entry_present, // present bit of context, process or first-level entry
    input wire logic lower_half_valid, // root entry lower half present
    input wire logic upper_half_valid, // root entry upper half present
    input wire logic rsvd_lo_nz, // reserved bits set in lower 64 bits / whole entry
    input wire logic rsvd_hi_nz, // reserved bits set in upper 64 bits of root entry
    input wire logic addr_width_bad, // addr_width_field unsupported or inconsistent
    input wire logic trans_type_bad, // translation type not supported
    input wire logic nested_en, // nested translation enabled in context
    input wire logic perm_read, // second-level read permission
    input wire logic perm_write, // second-level write permission
    input wire logic perm_exec, // second-level execute permission
    input wire logic exec_supported, // hardware supports execute permission
    input wire logic exec_enabled, // software enabled execute permission
    output logic busy, // walk in progress
    output logic walk_stop, // pulse: walker must stop now
    output logic resp_valid, // pulse: translation completion issued
    output logic resp_abort, // completion carries completer abort
    output logic fault_valid, // completion is the result of a fault
    output logic [REASON_W-1:0] fault_reason, // fault reason code
    output logic fault_qualified // fault is qualified
);

    // only four- and five-level paging tops are served
    if (LEVELS < 4 || LEVELS > 5) begin : g_levels_check
        $error("LEVELS must be 4 or 5");
    end

    // reason codes reach 17h, so the field needs five bits at least
    if (REASON_W < 5) begin : g_reason_check
        $error("REASON_W too narrow for the reason codes");
    end

    typedef struct packed {
        logic hit;
        logic [REASON_W-1:0] reason;
        logic qual;
    } verdict_t;

    function automatic verdict_t mk(input logic [REASON_W-1:0] r, input logic q);
        verdict_t v;
        v.hit = 1'b1;
        v.reason = r;
        v.qual = q;
        return v;
    endfunction

    function automatic verdict_t no_fault();
        verdict_t v;
        v.hit = 1'b0;
        v.reason = REASON_NONE;
        v.qual = 1'b0;
        return v;
    endfunction

    // root entry: a failed fetch leaves nothing to inspect
    function automatic verdict_t judge_root(
        input logic ferr,
        input logic lv,
        input logic uv,
        input logic rlo,
        input logic rhi
    );
        verdict_t v;
        v = no_fault();
        if (ferr) begin
            v = mk(REASON_ROOT_FETCH, 1'b0);
        end else if ((rlo && lv) || (rhi && uv)) begin
            v = mk(REASON_ROOT_RSVD, 1'b0);
        end
        return v;
    endfunction

    // context entry: reserved bits are judged before width and type
    function automatic verdict_t judge_ctx(
        input logic ferr,
        input logic pres,
        input logic rlo,
        input logic awb,
        input logic ttb
    );
        verdict_t v;
        v = no_fault();
        if (ferr) begin
            v = mk(REASON_CTX_FETCH, 1'b0);
        end else if (pres && rlo) begin
            v = mk(REASON_CTX_RSVD, 1'b0);
        end else if (pres && (awb || ttb)) begin
            v = mk(REASON_BAD_PROGRAM, 1'b1);
        end
        return v;
    endfunction

    // process id entry: a failed fetch means its address lay beyond host_addr_width
    function automatic verdict_t judge_pid(
        input logic ferr,
        input logic pres,
        input logic rlo
    );
        verdict_t v;
        v = no_fault();
        if (ferr) begin
            v = mk(REASON_BAD_PROGRAM, 1'b1);
        end else if (pres && rlo) begin
            v = mk(REASON_PID_RSVD, 1'b1);
        end
        return v;
    endfunction

    // second-level entry; a top fetch error without nesting counts as a plain 7h
    function automatic verdict_t judge_second(
        input logic ferr,
        input logic top,
        input logic nest,
        input logic perm,
        input logic rlo
    );
        verdict_t v;
        v = no_fault();
        if (ferr && top && nest) begin
            v = mk(REASON_BAD_PROGRAM, 1'b1);
        end else if (ferr) begin
            v = mk(REASON_SL_NEXT_FETCH, 1'b0);
        end else if (perm && rlo) begin
            v = mk(REASON_SL_RSVD, 1'b0);
        end
        return v;
    endfunction

    // first-level entry; only the top is fetched through first_level_table_pointer
    function automatic verdict_t judge_first(
        input logic ferr,
        input logic top,
        input logic pres,
        input logic rlo
    );
        verdict_t v;
        v = no_fault();
        if (ferr && top) begin
            v = mk(REASON_FL_TOP_FETCH, 1'b1);
        end else if (ferr) begin
            v = mk(REASON_FL_NEXT_FETCH, 1'b1);
        end else if (pres && rlo) begin
            v = mk(REASON_FL_RSVD, 1'b1);
        end
        return v;
    endfunction

    // fault test of one step; inside a step the fetch error comes first
    function automatic verdict_t judge(
        input logic [2:0] kind,
        input logic ferr,
        input logic pres,
        input logic lv,
        input logic uv,
        input logic rlo,
        input logic rhi,
        input logic awb,
        input logic ttb,
        input logic nest,
        input logic perm
    );
        verdict_t v;
        case (kind)
            STEP_ROOT: v = judge_root(ferr, lv, uv, rlo, rhi);
            STEP_CTX: v = judge_ctx(ferr, pres, rlo, awb, ttb);
            STEP_PID: v = judge_pid(ferr, pres, rlo);
            STEP_SL_TOP: v = judge_second(ferr, 1'b1, nest, perm, rlo);
            STEP_SL_NEXT: v = judge_second(ferr, 1'b0, nest, perm, rlo);
            STEP_FL_TOP: v = judge_first(ferr, 1'b1, pres, rlo);
            STEP_FL_NEXT: v = judge_first(ferr, 1'b0, pres, rlo);
            default: v = no_fault();
        endcase
        return v;
    endfunction

    logic perm_any;
    verdict_t step_v;

    walk_state_t state_r, state_nxt;
    logic busy_r, busy_nxt;
    logic stop_r, stop_nxt;
    logic resp_r, resp_nxt;
    logic abort_r, abort_nxt;
    logic fvalid_r, fvalid_nxt;
    logic [REASON_W-1:0] reason_r, reason_nxt;
    logic qual_r, qual_nxt;
    logic start_take;
    logic fault_take;
    logic clean_end;

    // a request is taken only in idle, a step only while walking
    always_comb begin
        start_take = (state_r == ST_IDLE) && req_start;
        fault_take = (state_r == ST_WALK) && step_valid && step_v.hit;
        clean_end = (state_r == ST_WALK) && step_valid && step_last && !step_v.hit;
    end

    always_comb begin
        // execute bit only counts when supported and enabled
        perm_any = perm_read || perm_write || (perm_exec && exec_supported && exec_enabled);
        step_v = judge(step_kind, fetch_err, entry_present, lower_half_valid, upper_half_valid,
                       rsvd_lo_nz, rsvd_hi_nz, addr_width_bad, trans_type_bad, nested_en, perm_any);
    end

    always_comb begin
        state_nxt = state_r;
        busy_nxt = busy_r;
        stop_nxt = 1'b0;
        resp_nxt = 1'b0;
        abort_nxt = abort_r;
        fvalid_nxt = fvalid_r;
        reason_nxt = reason_r;
        qual_nxt = qual_r;
        case (state_r)
            ST_IDLE: begin
                if (start_take) begin
                    state_nxt = ST_WALK;
                    busy_nxt = 1'b1;
                    abort_nxt = 1'b0;
                    fvalid_nxt = 1'b0;
                    reason_nxt = REASON_NONE;
                    qual_nxt = 1'b0;
                end
            end
            ST_WALK: begin
                if (fault_take) begin
                    // first fault in walk order is latched; later steps are ignored
                    state_nxt = ST_ANSWER;
                    stop_nxt = 1'b1;
                    abort_nxt = 1'b1;
                    fvalid_nxt = 1'b1;
                    reason_nxt = step_v.reason;
                    qual_nxt = step_v.qual;
                end else if (clean_end) begin
                    state_nxt = ST_ANSWER;
                end
            end
            ST_ANSWER: begin
                state_nxt = ST_IDLE;
                busy_nxt = 1'b0;
                resp_nxt = 1'b1;
            end
            default: begin
                state_nxt = ST_IDLE;
                busy_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            busy_r <= 1'b0;
            stop_r <= 1'b0;
            resp_r <= 1'b0;
            abort_r <= 1'b0;
            fvalid_r <= 1'b0;
            reason_r <= REASON_RST;
            qual_r <= QUALIFIED_RST;
        end else begin
            state_r <= state_nxt;
            busy_r <= busy_nxt;
            stop_r <= stop_nxt;
            resp_r <= resp_nxt;
            abort_r <= abort_nxt;
            fvalid_r <= fvalid_nxt;
            reason_r <= reason_nxt;
            qual_r <= qual_nxt;
        end
    end

    assign busy = busy_r;
    assign walk_stop = stop_r;
    assign resp_valid = resp_r;
    assign resp_abort = abort_r;
    assign fault_valid = fvalid_r;
    assign fault_reason = reason_r;
    assign fault_qualified = qual_r;

endmodule

// *** verification/fault_classify_assertions.sv ***
// port assertions of the translation fault classifier
`timescale 1ns/1ps
module fault_classify_assertions
    import fault_classify_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic reset_n, // async reset
    input wire logic req_start, // request start
    input wire logic step_valid, // step strobe
    input wire logic [2:0] step_kind, // step kind
    input wire logic fetch_err, // fetch error
    input wire logic busy, // walk busy
    input wire logic walk_stop, // stop pulse
    input wire logic resp_valid, // completion pulse
    input wire logic resp_abort, // abort status
    input wire logic fault_valid, // fault flag
    input wire logic [REASON_W-1:0] fault_reason, // reason code
    input wire logic fault_qualified // qualified flag
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);
    logic taken;
    // a step that the classifier looks at
    assign taken = busy && step_valid && !walk_stop;
    a_stop_then_resp: assert property (walk_stop |=> resp_valid && !walk_stop)
        else $error("stop without completion");
    a_resp_idle_abort: assert property (resp_valid |-> !busy && resp_abort == fault_valid)
        else $error("bad completion status");
    a_fault_has_reason: assert property (fault_valid |-> fault_reason != 8'h00)
        else $error("fault without reason");
    a_qual_map: assert property (fault_valid |->
        fault_qualified == (fault_reason inside {8'h03, 8'h13, 8'h15, 8'h16, 8'h17}))
        else $error("wrong qualified flag");
    a_root_fetch: assert property (taken && fetch_err && step_kind == 3'h0 |=>
        walk_stop && fault_reason == 8'h08)
        else $error("root fetch reason");
    a_ctx_fetch: assert property (taken && fetch_err && step_kind == 3'h1 |=>
        walk_stop && fault_reason == 8'h09 && !fault_qualified)
        else $error("context fetch reason");
    a_fl_top_fetch: assert property (taken && fetch_err && step_kind == 3'h5 |=>
        walk_stop && fault_reason == 8'h15)
        else $error("first-level top fetch reason");
    a_result_stands: assert property (!busy && !req_start |=>
        $stable(fault_reason) && $stable(fault_valid) && $stable(resp_abort) && $stable(fault_qualified))
        else $error("result changed in idle");
    c_fault: cover property (resp_valid && fault_valid);
    c_clean: cover property (resp_valid && !fault_valid);
    c_qualified: cover property (walk_stop && fault_qualified);
    c_refused_start: cover property (busy && req_start);
endmodule
bind fault_classify fault_classify_assertions u_chk (.clk(clk), .reset_n(reset_n), .req_start(req_start),
    .step_valid(step_valid), .step_kind(step_kind), .fetch_err(fetch_err), .busy(busy),
    .walk_stop(walk_stop), .resp_valid(resp_valid), .resp_abort(resp_abort),
    .fault_valid(fault_valid), .fault_reason(fault_reason), .fault_qualified(fault_qualified));

// *** verification/walker_model.sv ***
// model of the table walker that feeds walk steps
`timescale 1ns/1ps
module walker_model (
    input wire logic clk, // core clock
    output logic step_valid, // step strobe
    output logic [2:0] step_kind, // step kind
    output logic step_last, // final step
    output logic [13:0] flags // entry check results
);
    initial begin
        step_valid = 1'b0;
        step_kind = 3'h7;
        step_last = 1'b0;
        flags = 14'h2aaa;
    end
    // one step per call, in walk order; the strobe then drops and the other fields turn to their complements
    task automatic step(input logic [2:0] k, input logic l, input logic [13:0] f);
        @(posedge clk);
        #1;
        step_valid = 1'b1;
        step_kind = k;
        step_last = l;
        flags = f;
        @(posedge clk);
        #1;
        step_valid = 1'b0;
        step_kind = ~k;
        step_last = ~l;
        flags = ~f;
    endtask
endmodule

// *** verification/pasid_translation_fault_classifier_bench.sv ***
// self-checking bench of the translation fault classifier
`timescale 1ns/1ps
module pasid_translation_fault_classifier_bench;
    import fault_classify_pkg::*;
    localparam logic [13:0] FE = 14'h2000, PR = 14'h1000, LV = 14'h0800, UV = 14'h0400;
    localparam logic [13:0] RL = 14'h0200, RH = 14'h0100, WB = 14'h0080, TT = 14'h0040;
    localparam logic [13:0] NS = 14'h0020, RD = 14'h0010, WR = 14'h0008, EX = 14'h0004;
    localparam logic [13:0] XS = 14'h0002, XE = 14'h0001;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic req_start = 1'b0;
    logic step_valid, step_last, busy, walk_stop, resp_valid, resp_abort, fault_valid, fault_qualified;
    logic [2:0] step_kind;
    logic [13:0] flags;
    logic [REASON_W-1:0] fault_reason;
    int bad_count = 0;
    int compares = 0;
    int cycles = 0;
    always #50 clk = ~clk;
    walker_model u_walker (.clk(clk), .step_valid(step_valid), .step_kind(step_kind),
        .step_last(step_last), .flags(flags));
    fault_classify #(.LEVELS(5)) u_dut (.clk(clk), .reset_n(reset_n), .req_start(req_start),
        .step_valid(step_valid), .step_kind(step_kind), .step_last(step_last), .fetch_err(flags[13]),
        .entry_present(flags[12]), .lower_half_valid(flags[11]), .upper_half_valid(flags[10]),
        .rsvd_lo_nz(flags[9]), .rsvd_hi_nz(flags[8]), .addr_width_bad(flags[7]),
        .trans_type_bad(flags[6]), .nested_en(flags[5]), .perm_read(flags[4]), .perm_write(flags[3]),
        .perm_exec(flags[2]), .exec_supported(flags[1]), .exec_enabled(flags[0]), .busy(busy),
        .walk_stop(walk_stop), .resp_valid(resp_valid), .resp_abort(resp_abort),
        .fault_valid(fault_valid), .fault_reason(fault_reason), .fault_qualified(fault_qualified));
    task automatic conclude();
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic ok, input string what);
        compares++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("mismatch at %0t: %s", $time, what);
        end
    endtask
    task automatic start();
        @(posedge clk);
        #1;
        req_start = 1'b1;
        @(posedge clk);
        #1;
        req_start = 1'b0;
    endtask
    task automatic finish(input logic [7:0] er, input logic eq);
        int n;
        n = 0;
        while (resp_valid !== 1'b1 && n < 8) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(resp_valid === 1'b1 && busy === 1'b0, "no completion");
        check(fault_reason === er && fault_qualified === eq, "wrong reason");
        check(fault_valid === (er != 8'h00) && resp_abort === (er != 8'h00), "wrong abort");
    endtask
    task automatic one(input logic [2:0] k, input logic [13:0] f, input logic [7:0] er, input logic eq);
        start();
        u_walker.step(k, er == 8'h00, f);
        check(walk_stop === (er != 8'h00), "stop pulse");
        finish(er, eq);
    endtask
    task automatic idle_check(input string what);
        check(busy === 1'b0 && walk_stop === 1'b0 && resp_valid === 1'b0 && resp_abort === 1'b0, what);
        check(fault_valid === 1'b0 && fault_reason === REASON_RST && fault_qualified === QUALIFIED_RST, what);
    endtask
    task automatic t_root();
        one(3'h0, FE, 8'h08, 1'b0);
        one(3'h0, FE | LV | RL, 8'h08, 1'b0);
        one(3'h0, LV | RL, 8'h0a, 1'b0);
        one(3'h0, UV | RH, 8'h0a, 1'b0);
        one(3'h0, LV | RH, 8'h00, 1'b0);
    endtask
    task automatic t_ctx();
        one(3'h1, FE, 8'h09, 1'b0);
        one(3'h1, PR | WB, 8'h03, 1'b1);
        one(3'h1, PR | TT, 8'h03, 1'b1);
        one(3'h1, PR | RL, 8'h0b, 1'b0);
        one(3'h1, PR | RL | TT, 8'h0b, 1'b0);
    endtask
    task automatic t_pid();
        one(3'h2, FE, 8'h03, 1'b1);
        one(3'h2, PR | RL, 8'h13, 1'b1);
        one(3'h2, RL, 8'h00, 1'b0);
    endtask
    task automatic t_second();
        one(3'h3, FE | NS, 8'h03, 1'b1);
        one(3'h4, FE, 8'h07, 1'b0);
        one(3'h4, RL | RD, 8'h0c, 1'b0);
        one(3'h3, RL | WR, 8'h0c, 1'b0);
        one(3'h4, RL | EX | XS, 8'h00, 1'b0);
        one(3'h4, RL | EX | XS | XE, 8'h0c, 1'b0);
    endtask
    task automatic t_first();
        one(3'h5, FE, 8'h15, 1'b1);
        one(3'h6, PR | RL, 8'h16, 1'b1);
        one(3'h6, RL, 8'h00, 1'b0);
        one(3'h6, FE, 8'h17, 1'b1);
    endtask
    // clean steps, a refused restart mid-walk, then a late fault
    task automatic t_order();
        start();
        u_walker.step(3'h0, 1'b0, LV);
        start();
        u_walker.step(3'h1, 1'b0, PR);
        u_walker.step(3'h2, 1'b0, PR | RL);
        finish(8'h13, 1'b1);
    endtask
    // reset while a fault is pending clears everything, then a clean walk runs
    task automatic t_reset();
        start();
        u_walker.step(3'h1, 1'b0, FE);
        check(walk_stop === 1'b1 && fault_reason === REASON_CTX_FETCH, "no fault before reset");
        reset_n = 1'b0;
        #1;
        idle_check("reset mid-walk");
        @(posedge clk);
        #1;
        reset_n = 1'b1;
        one(3'h2, RL, 8'h00, 1'b0);
    endtask
    initial begin
        repeat (10) @(posedge clk);
        #1;
        idle_check("reset values");
        reset_n = 1'b1;
        t_root();
        t_ctx();
        t_pid();
        t_second();
        t_first();
        t_order();
        t_reset();
        conclude();
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            bad_count++;
            conclude();
        end
    end
endmodule
